// ---- inc/csam_map.vh ----
// Constants for the capacitive-sense accumulate, scan and pin-monitor control.
// Included by every design file under rtl/; holds definitions only.
`ifndef CSAM_MAP_VH
`define CSAM_MAP_VH

// =============================================================
// Sample-count select codes
`define CSAM_ACC_1        3'h0
`define CSAM_ACC_4        3'h1
`define CSAM_ACC_8        3'h2
`define CSAM_ACC_16       3'h3
`define CSAM_ACC_32       3'h4
`define CSAM_ACC_64       3'h5

// =============================================================
// Retry-limit select codes
`define CSAM_RETRY_ALL    2'h0
`define CSAM_RETRY_TWO    2'h1
`define CSAM_RETRY_FOUR   2'h2
`define CSAM_RETRY_CAP2   3'h2
`define CSAM_RETRY_CAP4   3'h4

// =============================================================
// Widths and reset values
`define CSAM_RES_W        16
`define CSAM_SUM_W        22
`define CSAM_CNT_W        7
`define CSAM_CNT_ONE      7'h01
`define CSAM_CNT_ZERO     7'h00
`define CSAM_SUM_ZERO     22'h00_0000
`define CSAM_RES_ZERO     16'h0000
`define CSAM_BYTE_ZERO    8'h00
`define CSAM_RETRY_ZERO   3'h0
`define CSAM_RETRY_ONE    3'h1

`endif

// ---- rtl/csam_acc_div.v ----
// Accumulator and divider for successive converter results.
// Assumes one sample_valid pulse per finished conversion, synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "csam_map.vh"

module csam_acc_div #(
    parameter RES_W = `CSAM_RES_W,
    parameter SUM_W = `CSAM_SUM_W
) (
    input  wire             ref_clk,
    input  wire             srst,
    input  wire             clear,
    input  wire [2:0]       sample_count_sel,
    input  wire             sample_valid,
    input  wire [RES_W-1:0] sample_data,
    output reg              avg_valid,
    output reg  [RES_W-1:0] avg_data
);

    // =============================================================
    // Count and shift decode
    // Count code decode
    function [`CSAM_CNT_W-1:0] count_of;
        input [2:0] sel;
        begin
            case (sel)
                `CSAM_ACC_4:  count_of = 7'd4;
                `CSAM_ACC_8:  count_of = 7'd8;
                `CSAM_ACC_16: count_of = 7'd16;
                `CSAM_ACC_32: count_of = 7'd32;
                `CSAM_ACC_64: count_of = 7'd64;
                // Reserved codes act as one sample
                default:      count_of = `CSAM_CNT_ONE;
            endcase
        end
    endfunction

    function [2:0] shift_of;
        input [2:0] sel;
        begin
            case (sel)
                `CSAM_ACC_4:  shift_of = 3'd2;
                `CSAM_ACC_8:  shift_of = 3'd3;
                `CSAM_ACC_16: shift_of = 3'd4;
                `CSAM_ACC_32: shift_of = 3'd5;
                `CSAM_ACC_64: shift_of = 3'd6;
                default:      shift_of = 3'd0;
            endcase
        end
    endfunction

    reg  [SUM_W-1:0]       sum_reg;
    reg  [`CSAM_CNT_W-1:0] cnt_reg;
    wire [SUM_W-1:0]       sum_next;
    wire [SUM_W-1:0]       quot;

    assign sum_next = sum_reg + {{(SUM_W-RES_W){1'b0}}, sample_data};
    assign quot     = sum_next >> shift_of(sample_count_sel);

    always @(posedge ref_clk) begin
        if (srst || clear) begin
            sum_reg   <= `CSAM_SUM_ZERO;
            cnt_reg   <= `CSAM_CNT_ZERO;
            avg_valid <= 1'b0;
            avg_data  <= `CSAM_RES_ZERO;
        end else begin
            avg_valid <= 1'b0;
            if (sample_valid) begin
                if (cnt_reg + `CSAM_CNT_ONE >= count_of(sample_count_sel)) begin
                    sum_reg   <= `CSAM_SUM_ZERO;
                    cnt_reg   <= `CSAM_CNT_ZERO;
                    avg_valid <= 1'b1;
                    avg_data  <= quot[RES_W-1:0];
                end else begin
                    sum_reg <= sum_next;
                    cnt_reg <= cnt_reg + `CSAM_CNT_ONE;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ---- rtl/csam_retry.v ----
// Pin-monitor retry arbiter: grants repeat requests up to the selected cap.
// Assumes switch events and conversion boundaries are synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "csam_map.vh"

module csam_retry (
    input  wire       ref_clk,
    input  wire       srst,
    input  wire       conv_start,
    input  wire       conv_active,
    input  wire [1:0] retry_limit_sel,
    input  wire       smbus_monitor_en,
    input  wire       port_write_monitor_en,
    input  wire       spi_monitor_en,
    input  wire       smbus_switch,
    input  wire       port_write_switch,
    input  wire       spi_switch,
    output wire       retry_grant
);

    reg  [2:0] used_reg;
    wire       request;
    reg        allowed;

    assign request = conv_active && ((smbus_monitor_en && smbus_switch)
                   || (port_write_monitor_en && port_write_switch)
                   || (spi_monitor_en && spi_switch));

    always @* begin
        case (retry_limit_sel)
            `CSAM_RETRY_TWO:  allowed = used_reg < `CSAM_RETRY_CAP2;
            `CSAM_RETRY_FOUR: allowed = used_reg < `CSAM_RETRY_CAP4;
            default:          allowed = 1'b1;
        endcase
    end

    assign retry_grant = request && allowed;

    always @(posedge ref_clk) begin
        if (srst) begin
            used_reg <= `CSAM_RETRY_ZERO;
        end else if (conv_start) begin
            // A grant on the restart edge still counts against the new cap
            used_reg <= retry_grant ? `CSAM_RETRY_ONE : `CSAM_RETRY_ZERO;
        end else if (retry_grant && used_reg != `CSAM_RETRY_CAP4) begin
            used_reg <= used_reg + `CSAM_RETRY_ONE;
        end
    end

endmodule
`default_nettype wire

// ---- rtl/csam_ctrl.v ----
// Capacitive-sense control: sequencing, averaging, compare, auto-scan, retry.
// Assumes an analogue core that answers conv_req with core_done and core_data,
// and redoes a portion when core_retry pulses. All inputs synchronous.
//
// How it works
// - Sum 1, 4, 8, 16, 32 or 64 conversions on the channel.
// - Count code 000..101 maps to 1..64; 11x reserved, treated as one.
// - After the last sample divide sum by count into result bytes.
// - Done flag rises only after M conversions, not each one.
// - Greater-than uses averaged result, strictly above threshold.
// - Auto-scan stops on greater-than, mux stays on that channel.
// - Otherwise auto-scan steps mux by one, wrapping end to start.
// - Without auto-scan the mux never changes after conversions.
// - Enabled monitor event during conversion repeats the corrupted portion.
// - Retry limit resets to unlimited; may cap at two or four.
// - Any retry sets event flag until software clear or reset.
// - SMBus, port-write and SPI monitor enables, each reset to zero.
`timescale 1ns/1ns
`default_nettype none
`include "csam_map.vh"

module csam_ctrl #(
    parameter RES_W = `CSAM_RES_W,
    parameter SUM_W = `CSAM_SUM_W,
    parameter CH_W  = 6
) (
    input  wire            ref_clk,
    input  wire            srst,
    input  wire            sense_enable,
    input  wire            start_pulse,
    input  wire            continuous_en,
    input  wire            auto_scan_en,
    input  wire            compare_en,
    input  wire [2:0]      sample_count_sel,
    input  wire [CH_W-1:0] scan_start_channel,
    input  wire            scan_start_write,
    input  wire [CH_W-1:0] scan_end_channel,
    input  wire [CH_W-1:0] channel_mux_wdata,
    input  wire            channel_mux_write,
    input  wire [7:0]      threshold_high_byte,
    input  wire [7:0]      threshold_low_byte,
    input  wire            done_flag_clear,
    input  wire            greater_flag_clear,
    input  wire            retry_flag_clear,
    input  wire [1:0]      retry_limit_sel,
    input  wire            smbus_monitor_en,
    input  wire            port_write_monitor_en,
    input  wire            spi_monitor_en,
    input  wire            smbus_switch,
    input  wire            port_write_switch,
    input  wire            spi_switch,
    input  wire            core_done,
    input  wire [RES_W-1:0] core_data,
    output reg             conv_req,
    output reg             core_retry,
    output reg             busy,
    output reg  [CH_W-1:0] channel_mux_sel,
    output reg  [7:0]      result_high_byte,
    output reg  [7:0]      result_low_byte,
    output reg             conversion_done_flag,
    output reg             greater_flag,
    output reg             retry_event_flag
);

    // =============================================================
    // States
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CONV = 3'b010;
    localparam [2:0] ST_EVAL = 3'b100;

    reg  [2:0]       state_reg;
    reg  [2:0]       state_next;
    wire             avg_valid;
    wire [RES_W-1:0] avg_data;
    wire             retry_grant;
    wire [RES_W-1:0] threshold;
    wire             above;
    wire             conv_start;
    reg              sample_seen_reg;

    assign threshold  = {threshold_high_byte, threshold_low_byte};
    assign conv_start = (state_reg == ST_IDLE) && sense_enable && start_pulse;

    // =============================================================
    // Averaging
    csam_acc_div #(
        .RES_W (RES_W),
        .SUM_W (SUM_W)
    ) u_acc (
        .ref_clk          (ref_clk),
        .srst             (srst),
        .clear            (conv_start),
        .sample_count_sel (sample_count_sel),
        .sample_valid     (core_done && state_reg == ST_CONV),
        .sample_data      (core_data),
        .avg_valid        (avg_valid),
        .avg_data         (avg_data)
    );

    // =============================================================
    // Pin-monitor retry
    csam_retry u_retry (
        .ref_clk               (ref_clk),
        .srst                  (srst),
        .conv_start            (conv_req),
        .conv_active           (state_reg == ST_CONV),
        .retry_limit_sel       (retry_limit_sel),
        .smbus_monitor_en      (smbus_monitor_en),
        .port_write_monitor_en (port_write_monitor_en),
        .spi_monitor_en        (spi_monitor_en),
        .smbus_switch          (smbus_switch),
        .port_write_switch     (port_write_switch),
        .spi_switch            (spi_switch),
        .retry_grant           (retry_grant)
    );

    assign above = compare_en && (avg_data > threshold);

    // =============================================================
    // Sequencer
    always @* begin
        case (state_reg)
            ST_IDLE: state_next = conv_start ? ST_CONV : ST_IDLE;
            ST_CONV: state_next = avg_valid ? ST_EVAL : ST_CONV;
            ST_EVAL: begin
                if (continuous_en && sense_enable && !above)
                    state_next = ST_CONV;
                else
                    state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            conv_req  <= 1'b0;
            busy      <= 1'b0;
            sample_seen_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy      <= state_next != ST_IDLE;
            sample_seen_reg <= core_done && (state_reg == ST_CONV);
            // Wait one cycle so avg_valid can veto a request past the last sample
            conv_req  <= (state_next == ST_CONV)
                      && (state_reg != ST_CONV || (sample_seen_reg && !avg_valid));
        end
    end

    always @(posedge ref_clk) begin
        if (srst)
            core_retry <= 1'b0;
        else
            core_retry <= retry_grant;
    end

    // =============================================================
    // Result bytes
    always @(posedge ref_clk) begin
        if (srst) begin
            result_high_byte <= `CSAM_BYTE_ZERO;
            result_low_byte  <= `CSAM_BYTE_ZERO;
        end else if (avg_valid) begin
            result_high_byte <= avg_data[RES_W-1:RES_W-8];
            result_low_byte  <= avg_data[7:0];
        end
    end

    // =============================================================
    // Flags; a set in the same cycle as a clear wins
    always @(posedge ref_clk) begin
        if (srst) begin
            conversion_done_flag <= 1'b0;
            greater_flag         <= 1'b0;
            retry_event_flag     <= 1'b0;
        end else begin
            if (avg_valid)
                conversion_done_flag <= 1'b1;
            else if (done_flag_clear)
                conversion_done_flag <= 1'b0;
            if (avg_valid && above)
                greater_flag <= 1'b1;
            else if (greater_flag_clear)
                greater_flag <= 1'b0;
            if (retry_grant)
                retry_event_flag <= 1'b1;
            else if (retry_flag_clear)
                retry_event_flag <= 1'b0;
        end
    end

    // =============================================================
    // Channel multiplexer
    always @(posedge ref_clk) begin
        if (srst) begin
            channel_mux_sel <= {CH_W{1'b0}};
        end else if (state_reg == ST_IDLE && channel_mux_write) begin
            channel_mux_sel <= channel_mux_wdata;
        end else if (auto_scan_en && scan_start_write && state_reg == ST_IDLE) begin
            channel_mux_sel <= scan_start_channel;
        end else if (state_reg == ST_EVAL && auto_scan_en && !above) begin
            if (channel_mux_sel == scan_end_channel)
                channel_mux_sel <= scan_start_channel;
            else
                channel_mux_sel <= channel_mux_sel + {{(CH_W-1){1'b0}}, 1'b1};
        end
    end

endmodule
`default_nettype wire

// ---- dv/csam_monitor.sv ----
// Port checker for csam_ctrl, bound at the foot of this file.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module csam_monitor (
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic       sense_enable,
    input wire logic       start_pulse,
    input wire logic       compare_en,
    input wire logic       done_flag_clear,
    input wire logic       retry_flag_clear,
    input wire logic       smbus_monitor_en,
    input wire logic       port_write_monitor_en,
    input wire logic       spi_monitor_en,
    input wire logic       smbus_switch,
    input wire logic       port_write_switch,
    input wire logic       spi_switch,
    input wire logic       core_done,
    input wire logic       conv_req,
    input wire logic       core_retry,
    input wire logic       busy,
    input wire logic [7:0] result_high_byte,
    input wire logic [7:0] result_low_byte,
    input wire logic       conversion_done_flag,
    input wire logic       greater_flag,
    input wire logic       retry_event_flag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // =========================================
    // Conversion sequencing and results
    a_start_req: assert property (start_pulse && !busy && sense_enable |=> conv_req && busy)
        else $error("start not answered");
    a_done_cause: assert property ($rose(conversion_done_flag) |-> $past(core_done, 2))
        else $error("done flag without a final sample");
    a_done_sticky: assert property (conversion_done_flag && !done_flag_clear |=> conversion_done_flag)
        else $error("done flag dropped on its own");
    a_result_cause: assert property ($changed({result_high_byte, result_low_byte}) |-> $past(core_done, 2))
        else $error("result moved without a sample");
    a_greater_cause: assert property ($rose(greater_flag) |-> $past(core_done, 2) && compare_en)
        else $error("greater flag without a compare");
    // =========================================
    // Pin-monitor retries
    a_retry_cause: assert property (core_retry |-> $past((smbus_switch && smbus_monitor_en)
        || (port_write_switch && port_write_monitor_en) || (spi_switch && spi_monitor_en)))
        else $error("retry without an enabled event");
    a_retry_flags: assert property (core_retry |-> ##[0:1] retry_event_flag)
        else $error("retry left no event flag");
    a_event_sticky: assert property (retry_event_flag && !retry_flag_clear |=> retry_event_flag)
        else $error("event flag dropped on its own");
    c_greater: cover property ($rose(greater_flag));
    c_retry: cover property ($rose(retry_event_flag));
    c_done: cover property ($rose(conversion_done_flag));
endmodule
bind csam_ctrl csam_monitor u_mon (.*);
`default_nettype wire

// ---- dv/csam_core_model.sv ----
// Behavioural analogue core answering each conversion request after a delay.
// Assumes single-cycle request and retry pulses on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module csam_core_model (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        conv_req,
    input  wire logic        core_retry,
    input  wire logic        sync_clr,
    input  wire logic        slow,
    input  wire logic [15:0] sample_level,
    output logic             core_done,
    output logic [15:0]      core_data
);
    logic [3:0]  wait_cnt;
    logic        pend;
    logic [6:0]  k;
    logic [15:0] last;

    // Odd samples sit two higher, so even-count averages come out one above the level
    always @(posedge ref_clk) begin
        core_done <= 1'b0;
        if (srst || sync_clr) begin
            pend <= 1'b0;
            k    <= 7'h00;
            last <= 16'h0000;
        end else if (conv_req) begin
            pend     <= 1'b1;
            wait_cnt <= slow ? 4'hB : 4'h2;
        end else if (pend && core_retry) begin
            wait_cnt <= slow ? 4'hB : 4'h2;
        end else if (pend && wait_cnt == 4'h0) begin
            pend      <= 1'b0;
            core_done <= 1'b1;
            last      <= sample_level + (k[0] ? 16'h0002 : 16'h0000);
            k         <= k + 7'h01;
        end else if (pend) begin
            wait_cnt <= wait_cnt - 4'h1;
        end
    end
    // Outside a done pulse the bus shows junk, never the stale sample
    assign core_data = core_done ? last : ~last;
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the capacitive-sense control block.
// Assumes csam_ctrl, the core model and the bound checker are compiled.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    typedef struct {logic [2:0] sel; logic [15:0] lvl, avg, m; logic gt;} csam_row_t;
    logic ref_clk = 0, srst = 1, sense_enable = 1, start_pulse = 0, continuous_en = 0, auto_scan_en = 0;
    logic compare_en = 1, scan_start_write = 0, channel_mux_write = 0, done_flag_clear = 0;
    logic greater_flag_clear = 0, retry_flag_clear = 0, smbus_monitor_en = 0, port_write_monitor_en = 0;
    logic spi_monitor_en = 0, smbus_switch = 0, port_write_switch = 0, spi_switch = 0, slow = 0;
    logic [2:0] sample_count_sel = 0;
    logic [1:0] retry_limit_sel = 0;
    logic [5:0] scan_start_channel = 0, scan_end_channel = 0, channel_mux_wdata = 0, channel_mux_sel;
    logic [7:0] threshold_high_byte = 8'h80, threshold_low_byte = 8'h00, result_high_byte, result_low_byte;
    logic [15:0] sample_level = 0, core_data;
    logic core_done, conv_req, core_retry, busy, conversion_done_flag, greater_flag, retry_event_flag;
    int err_total = 0, n_tests = 0, n_done = 0, n_retry = 0;
    int exp_rt [5] = '{0, 6, 2, 4, 6};
    logic [5:0] exp_mux [4] = '{6'h03, 6'h04, 6'h02, 6'h03};
    csam_row_t rows [8];

    csam_ctrl dut (.*);
    csam_core_model u_core (.sync_clr(start_pulse), .*);

    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (core_done) n_done++;
        if (core_retry) n_retry++;
    end

    task tick;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick;
        s = 1'b0;
    endtask
    task chk(input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task wait_until(input logic idle);
        int c;
        c = 0;
        while (idle ? busy !== 1'b0 : conversion_done_flag !== 1'b1) begin
            if (++c > 5000) begin
                err_total++;
                summarize;
            end
            tick;
        end
    endtask

    initial begin
        rows = '{'{3'h0, 16'h8000, 16'h8000, 16'h0001, 1'b0}, '{3'h1, 16'h7FFF, 16'h8000, 16'h0004, 1'b0},
                 '{3'h2, 16'h8000, 16'h8001, 16'h0008, 1'b1}, '{3'h3, 16'h0123, 16'h0124, 16'h0010, 1'b0},
                 '{3'h4, 16'h4000, 16'h4001, 16'h0020, 1'b0}, '{3'h5, 16'hFFF0, 16'hFFF1, 16'h0040, 1'b1},
                 '{3'h6, 16'h1234, 16'h1234, 16'h0001, 1'b0}, '{3'h7, 16'h8001, 16'h8001, 16'h0001, 1'b1}};
        repeat (10) @(posedge ref_clk);
        #1 srst = 1'b0;
        chk({busy, conv_req, conversion_done_flag, greater_flag, retry_event_flag, channel_mux_sel, 5'h00},
            16'h0000);
        chk({result_high_byte, result_low_byte}, 16'h0000);
        channel_mux_wdata = 6'h05;
        pulse(channel_mux_write);
        // =========================================
        // Averaging table
        foreach (rows[i]) begin
            sample_count_sel = rows[i].sel;
            sample_level = rows[i].lvl;
            n_done = 0;
            pulse(start_pulse);
            wait_until(1'b0);
            chk(16'(n_done), rows[i].m);
            chk({result_high_byte, result_low_byte}, rows[i].avg);
            chk({15'h0, greater_flag}, {15'h0, rows[i].gt});
            chk({10'h0, channel_mux_sel}, 16'h0005);
            wait_until(1'b1);
            done_flag_clear = 1'b1;
            greater_flag_clear = 1'b1;
            tick;
            done_flag_clear = 1'b0;
            greater_flag_clear = 1'b0;
        end
        // =========================================
        // Auto-scan wrap, then stop on greater-than
        sample_count_sel = 3'h1;
        sample_level = 16'h1000;
        scan_start_channel = 6'h02;
        scan_end_channel = 6'h04;
        auto_scan_en = 1'b1;
        continuous_en = 1'b1;
        pulse(scan_start_write);
        chk({10'h0, channel_mux_sel}, 16'h0002);
        pulse(start_pulse);
        foreach (exp_mux[j]) begin
            wait_until(1'b0);
            pulse(done_flag_clear);
            tick;
            chk({10'h0, channel_mux_sel}, {10'h0, exp_mux[j]});
        end
        sample_level = 16'hF000;
        wait_until(1'b1);
        chk({10'h0, channel_mux_sel}, 16'h0003);
        chk({15'h0, greater_flag}, 16'h0001);
        auto_scan_en = 1'b0;
        continuous_en = 1'b0;
        // =========================================
        // Retries under each limit; first pass has monitors off
        slow = 1'b1;
        sample_count_sel = 3'h0;
        foreach (exp_rt[r]) begin
            {spi_monitor_en, port_write_monitor_en, smbus_monitor_en} = (r == 0) ? 3'h0 : 3'h3;
            retry_limit_sel = (r == 0) ? 2'h0 : 2'(r - 1);
            n_retry = 0;
            pulse(start_pulse);
            for (int j = 0; j < 6; j++) begin
                {spi_switch, port_write_switch, smbus_switch} = j[0] ? 3'h6 : 3'h5;
                tick;
                {spi_switch, port_write_switch, smbus_switch} = 3'h4;
                tick;
            end
            {spi_switch, port_write_switch, smbus_switch} = 3'h0;
            wait_until(1'b1);
            chk(16'(n_retry), 16'(exp_rt[r]));
            chk({15'h0, retry_event_flag}, {15'h0, r != 0});
            pulse(retry_flag_clear);
            chk({15'h0, retry_event_flag}, 16'h0000);
        end
        tick;
        summarize;
    end
endmodule
`default_nettype wire
